// [shared/ldoscr_defines.svh]
// register indices, field positions, reset values and codes of the regulator control bank
`ifndef LDOSCR_DEFINES_SVH
`define LDOSCR_DEFINES_SVH
`define LDOSCR_IDX_A_SLEEP 16'h4073
`define LDOSCR_IDX_B_CTRL 16'h4074
`define LDOSCR_IDX_B_ON 16'h4075
`define LDOSCR_IDX_B_SLEEP 16'h4076
`define LDOSCR_IDX_IRQ_STAT 16'h4080
`define LDOSCR_IDX_IRQ_CLR 16'h4081
`define LDOSCR_IDX_IRQ_EN 16'h4082
`define LDOSCR_SLOT_MSB 15
`define LDOSCR_SLOT_LSB 13
`define LDOSCR_MODE_BIT 8
`define LDOSCR_VSEL_MSB 4
`define LDOSCR_VSEL_LSB 0
`define LDOSCR_ACT_MSB 15
`define LDOSCR_ACT_LSB 14
`define LDOSCR_SRC_MSB 12
`define LDOSCR_SRC_LSB 11
`define LDOSCR_PICK_BIT 10
`define LDOSCR_HWM_MSB 9
`define LDOSCR_HWM_LSB 8
`define LDOSCR_FLT_BIT 7
`define LDOSCR_SWI_BIT 6
`define LDOSCR_LP_BIT 0
`define LDOSCR_RST_SLOT 3'h0
`define LDOSCR_RST_SLP_MODE 1'h1
`define LDOSCR_RST_ON_MODE 1'h0
`define LDOSCR_RST_VSEL 5'h00
`define LDOSCR_RST_ACT 2'h0
`define LDOSCR_RST_SRC 2'h0
`define LDOSCR_RST_PICK 1'h0
`define LDOSCR_RST_HWM 2'h2
`define LDOSCR_RST_FLT 1'h0
`define LDOSCR_RST_SWI 1'h0
`define LDOSCR_RST_LP 1'h0
`define LDOSCR_ST_W 3
`define LDOSCR_ST_UV 0
`define LDOSCR_ST_SLP 1
`define LDOSCR_ST_OFF 2
`define LDOSCR_RST_ST 3'h0
`define LDOSCR_TS1 3'h1
`define LDOSCR_TS2 3'h2
`define LDOSCR_TS3 3'h3
`define LDOSCR_TS4 3'h4
`define LDOSCR_TS5 3'h5
`define LDOSCR_SLOT_DIS_LO 3'h1
`define LDOSCR_SLOT_DIS_HI 3'h5
`endif

// [shared/ldoscr_pkg.sv]
// types shared by the regulator control bank
package ldoscr_pkg;
  typedef enum logic [1:0] {
    LDOSCR_SLP_AWAKE = 2'b00,
    LDOSCR_SLP_ARMED = 2'b01,
    LDOSCR_SLP_SLEEP = 2'b10,
    LDOSCR_SLP_OFF = 2'b11
  } ldoscr_slp_state_e;
  typedef enum logic [1:0] {
    LDOSCR_HWM_LP0 = 2'b00,
    LDOSCR_HWM_OFF = 2'b01,
    LDOSCR_HWM_LP2 = 2'b10,
    LDOSCR_HWM_ON = 2'b11
  } ldoscr_hwmode_e;
  typedef enum logic [1:0] {
    LDOSCR_ACT_IGNORE = 2'b00,
    LDOSCR_ACT_SHUT = 2'b01,
    LDOSCR_ACT_SYSRST = 2'b10,
    LDOSCR_ACT_RSVD = 2'b11
  } ldoscr_act_e;
  typedef enum logic [1:0] {
    LDOSCR_SRC_NONE = 2'b00,
    LDOSCR_SRC_HW1 = 2'b01,
    LDOSCR_SRC_HW2 = 2'b10,
    LDOSCR_SRC_EITHER = 2'b11
  } ldoscr_src_e;
endpackage

// [shared/ldoscr_fields_if.sv]
// register fields handed from the register bank to the regulator control logic
`timescale 1ns/100ps
`default_nettype none
interface ldoscr_fields_if;
  logic [2:0] reg_a_sleep_slot;
  logic reg_a_sleep_op_mode;
  logic [4:0] reg_a_sleep_voltage_code;
  ldoscr_pkg::ldoscr_act_e reg_b_undervoltage_action;
  ldoscr_pkg::ldoscr_src_e reg_b_hw_control_source;
  logic reg_b_hw_control_voltage_pick;
  ldoscr_pkg::ldoscr_hwmode_e reg_b_hw_control_op_mode;
  logic reg_b_output_float;
  logic reg_b_switch_select;
  logic reg_b_low_power_variant;
  logic [4:0] reg_b_on_voltage_code;
  logic reg_b_on_op_mode;
  logic [4:0] reg_b_sleep_voltage_code;
  modport regs (
    output reg_a_sleep_slot, reg_a_sleep_op_mode, reg_a_sleep_voltage_code,
    output reg_b_undervoltage_action, reg_b_hw_control_source,
    output reg_b_hw_control_voltage_pick, reg_b_hw_control_op_mode, reg_b_output_float,
    output reg_b_switch_select, reg_b_low_power_variant, reg_b_on_voltage_code,
    output reg_b_on_op_mode, reg_b_sleep_voltage_code
  );
  modport ctrl (
    input reg_a_sleep_slot, reg_a_sleep_op_mode, reg_a_sleep_voltage_code,
    input reg_b_undervoltage_action, reg_b_hw_control_source,
    input reg_b_hw_control_voltage_pick, reg_b_hw_control_op_mode, reg_b_output_float,
    input reg_b_switch_select, reg_b_low_power_variant, reg_b_on_voltage_code,
    input reg_b_on_op_mode, reg_b_sleep_voltage_code
  );
endinterface
`default_nettype wire

// [rtl/ldoscr_sleep_slot.sv]
// sleep-entry timeslot logic of regulator a
`timescale 1ns/100ps
`default_nettype none
`include "ldoscr_defines.svh"
module ldoscr_sleep_slot (
  input wire logic pclk,
  input wire logic presetn,
  ldoscr_fields_if.ctrl f,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic timeslot_strobe,
  input wire logic [2:0] timeslot_num,
  input wire logic hw_enable_assigned,
  output logic sleep_active,
  output logic reg_off,
  output logic evt_sleep,
  output logic evt_off
);
  ldoscr_pkg::ldoscr_slp_state_e state_ff, nxt_state;
  logic evt_sleep_ff, nxt_evt_sleep;
  logic evt_off_ff, nxt_evt_off;
  logic [2:0] target;
  logic dis_code;

  always_comb
  begin
    case (f.reg_a_sleep_slot)
      3'h0: target = `LDOSCR_TS5;
      3'h1: target = `LDOSCR_TS5;
      3'h2: target = `LDOSCR_TS4;
      3'h3: target = `LDOSCR_TS3;
      3'h4: target = `LDOSCR_TS2;
      3'h5: target = `LDOSCR_TS1;
      3'h6: target = `LDOSCR_TS3;
      3'h7: target = `LDOSCR_TS1;
      default: target = `LDOSCR_TS5;
    endcase
  end

  // hardware-enabled regulator only sleeps in its slot, never shuts
  assign dis_code = (f.reg_a_sleep_slot >= `LDOSCR_SLOT_DIS_LO)
    && (f.reg_a_sleep_slot <= `LDOSCR_SLOT_DIS_HI) && !hw_enable_assigned;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_evt_sleep = 1'b0;
    nxt_evt_off = 1'b0;
    case (state_ff)
      ldoscr_pkg::LDOSCR_SLP_AWAKE:
      begin
        if (sleep_req)
          nxt_state = ldoscr_pkg::LDOSCR_SLP_ARMED;
      end
      ldoscr_pkg::LDOSCR_SLP_ARMED:
      begin
        if (timeslot_strobe && timeslot_num == target)
        begin
          if (dis_code)
          begin
            nxt_state = ldoscr_pkg::LDOSCR_SLP_OFF;
            nxt_evt_off = 1'b1;
          end
          else
          begin
            nxt_state = ldoscr_pkg::LDOSCR_SLP_SLEEP;
            nxt_evt_sleep = 1'b1;
          end
        end
      end
      default:
      begin
      end
    endcase
    // wake wins over a slot strobe in the same cycle
    if (wake_req)
      nxt_state = ldoscr_pkg::LDOSCR_SLP_AWAKE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ldoscr_pkg::LDOSCR_SLP_AWAKE;
      evt_sleep_ff <= 1'b0;
      evt_off_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      evt_sleep_ff <= nxt_evt_sleep;
      evt_off_ff <= nxt_evt_off;
    end
  end

  assign sleep_active = (state_ff == ldoscr_pkg::LDOSCR_SLP_SLEEP);
  assign reg_off = (state_ff == ldoscr_pkg::LDOSCR_SLP_OFF);
  assign evt_sleep = evt_sleep_ff;
  assign evt_off = evt_off_ff;
endmodule // ldoscr_sleep_slot
`default_nettype wire

// [rtl/ldoscr_hw_ctrl.sv]
// hardware control and undervoltage handling of regulator b
`timescale 1ns/100ps
`default_nettype none
module ldoscr_hw_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  ldoscr_fields_if.ctrl f,
  input wire logic hw1,
  input wire logic hw2,
  input wire logic uv,
  input wire logic uv_clr,
  input wire logic seq_on,
  output logic enable,
  output logic [4:0] voltage_code,
  output logic low_power,
  output logic discharge,
  output logic switch_mode,
  output logic lp_variant,
  output logic hwc_active,
  output logic sys_reset_req,
  output logic uv_event
);
  logic uv_prev_ff, nxt_uv_prev;
  logic shut_ff, nxt_shut;
  logic sysrst_ff, nxt_sysrst;
  logic evt_ff, nxt_evt;
  logic en_ff, nxt_en;
  logic [4:0] vcode_ff, nxt_vcode;
  logic lp_ff, nxt_lp;
  logic dis_ff, nxt_dis;
  logic swi_ff, nxt_swi;
  logic lpv_ff, nxt_lpv;
  logic hwa_ff, nxt_hwa;
  logic hw_on;
  logic uv_rise;

  always_comb
  begin
    case (f.reg_b_hw_control_source)
      ldoscr_pkg::LDOSCR_SRC_HW1: hw_on = hw1;
      ldoscr_pkg::LDOSCR_SRC_HW2: hw_on = hw2;
      ldoscr_pkg::LDOSCR_SRC_EITHER: hw_on = hw1 | hw2;
      default: hw_on = 1'b0;
    endcase
  end

  assign uv_rise = uv && !uv_prev_ff;

  always_comb
  begin
    nxt_uv_prev = uv;
    nxt_evt = uv_rise;
    nxt_sysrst = uv_rise && (f.reg_b_undervoltage_action == ldoscr_pkg::LDOSCR_ACT_SYSRST);
    nxt_shut = shut_ff;
    if (uv_clr)
      nxt_shut = 1'b0;
    // a new fault beats a clear in the same cycle
    if (uv_rise && f.reg_b_undervoltage_action == ldoscr_pkg::LDOSCR_ACT_SHUT)
      nxt_shut = 1'b1;
    nxt_hwa = hw_on;
    nxt_vcode = (hw_on && f.reg_b_hw_control_voltage_pick) ?
      f.reg_b_sleep_voltage_code : f.reg_b_on_voltage_code;
    nxt_en = (seq_on || hw_on) && !nxt_shut
      && !(hw_on && f.reg_b_hw_control_op_mode == ldoscr_pkg::LDOSCR_HWM_OFF);
    if (hw_on && f.reg_b_hw_control_op_mode != ldoscr_pkg::LDOSCR_HWM_ON)
      nxt_lp = 1'b1;
    else
      nxt_lp = f.reg_b_on_op_mode;
    nxt_dis = !nxt_en && !f.reg_b_output_float;
    nxt_swi = f.reg_b_switch_select;
    nxt_lpv = f.reg_b_low_power_variant;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uv_prev_ff <= 1'b0;
      evt_ff <= 1'b0;
      sysrst_ff <= 1'b0;
      shut_ff <= 1'b0;
      hwa_ff <= 1'b0;
      vcode_ff <= 5'h00;
      en_ff <= 1'b0;
      lp_ff <= 1'b0;
      dis_ff <= 1'b1;
      swi_ff <= 1'b0;
      lpv_ff <= 1'b0;
    end
    else
    begin
      uv_prev_ff <= nxt_uv_prev;
      evt_ff <= nxt_evt;
      sysrst_ff <= nxt_sysrst;
      shut_ff <= nxt_shut;
      hwa_ff <= nxt_hwa;
      vcode_ff <= nxt_vcode;
      en_ff <= nxt_en;
      lp_ff <= nxt_lp;
      dis_ff <= nxt_dis;
      swi_ff <= nxt_swi;
      lpv_ff <= nxt_lpv;
    end
  end

  assign enable = en_ff;
  assign voltage_code = vcode_ff;
  assign low_power = lp_ff;
  assign discharge = dis_ff;
  assign switch_mode = swi_ff;
  assign lp_variant = lpv_ff;
  assign hwc_active = hwa_ff;
  assign sys_reset_req = sysrst_ff;
  assign uv_event = evt_ff;
endmodule // ldoscr_hw_ctrl
`default_nettype wire

// [rtl/ldoscr_top.sv]
// regulator sleep and control register bank with apb slave and interrupt
//
// Operation
// - sleep slot codes 000, 110 and 111 apply sleep voltage and mode in timeslot 5, 3 and 1, reset 000.
// - sleep slot codes 001 to 101 switch regulator a off in timeslot 5 down to timeslot 1.
// - with a hardware enable assigned, codes 001 to 101 pick the sleep-entry slot instead of off.
// - sleep register bit 8 picks the sleep mode, 0 normal and 1 low power, reset 1.
// - sleep voltage code in bits 4:0 spans 0.90 V to 3.30 V in two step sizes, reset zero.
// - bits 15:14 pick the undervoltage action: ignore, regulator off, system reset, reserved.
// - an undervoltage always raises the interrupt event whatever the action.
// - bits 12:11 pick the hardware control source: none, input 1, input 2 or either.
// - bit 10 picks the on or the sleep voltage code under hardware control, reset 0.
// - bits 9:8 give low power, off, low power or the on mode under hardware control, reset 10.
// - bit 7 picks discharge or float of the disabled output, reset 0.
// - bit 0 picks the 50 mA or 20 mA low power variant, reset 0.
// - the on voltage code is five bits with the same mapping, reset zero.
`timescale 1ns/100ps
`default_nettype none
`include "ldoscr_defines.svh"
module ldoscr_top #(
  parameter int ADDR_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hardware_control_1,
  input wire logic hardware_control_2,
  input wire logic reg_b_undervoltage,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic timeslot_strobe,
  input wire logic [2:0] timeslot_num,
  input wire logic reg_a_hw_enable_assigned,
  input wire logic reg_b_seq_on,
  output logic reg_a_sleep_active,
  output logic reg_a_off,
  output logic [4:0] reg_a_voltage_code,
  output logic reg_a_low_power,
  output logic reg_b_enable,
  output logic [4:0] reg_b_voltage_code,
  output logic reg_b_low_power,
  output logic reg_b_discharge,
  output logic reg_b_switch_mode,
  output logic reg_b_lp_variant,
  output logic reg_b_hwc_active,
  output logic system_reset_req,
  output logic irq
);
  ldoscr_fields_if fif();

  logic [2:0] a_slot_ff, nxt_a_slot;
  logic a_mode_ff, nxt_a_mode;
  logic [4:0] a_vsel_ff, nxt_a_vsel;
  logic [1:0] b_act_ff, nxt_b_act;
  logic [1:0] b_src_ff, nxt_b_src;
  logic b_pick_ff, nxt_b_pick;
  logic [1:0] b_hwm_ff, nxt_b_hwm;
  logic b_flt_ff, nxt_b_flt;
  logic b_swi_ff, nxt_b_swi;
  logic b_lp_ff, nxt_b_lp;
  logic [4:0] b_on_vsel_ff, nxt_b_on_vsel;
  logic b_on_mode_ff, nxt_b_on_mode;
  logic [4:0] b_slp_vsel_ff, nxt_b_slp_vsel;
  logic b_slp_mode_ff, nxt_b_slp_mode;
  logic [`LDOSCR_ST_W-1:0] stat_ff, nxt_stat;
  logic [`LDOSCR_ST_W-1:0] en_ff, nxt_en;
  logic irq_ff, nxt_irq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic [2:0] meta_ff, nxt_meta;
  logic [2:0] sync_ff, nxt_sync;

  logic [15:0] idx;
  logic aligned;
  logic setup;
  logic wr;
  logic hit_a, hit_b, hit_on, hit_bs, hit_st, hit_clr, hit_en;
  logic mapped;
  logic [`LDOSCR_ST_W-1:0] clr_mask;
  logic [`LDOSCR_ST_W-1:0] evts;
  logic [31:0] rd;
  logic evt_sleep, evt_off, uv_event;

  // bus index is word address; printed offsets are indices, byte address is 4x
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && aligned;
  assign hit_a = (idx == `LDOSCR_IDX_A_SLEEP);
  assign hit_b = (idx == `LDOSCR_IDX_B_CTRL);
  assign hit_on = (idx == `LDOSCR_IDX_B_ON);
  assign hit_bs = (idx == `LDOSCR_IDX_B_SLEEP);
  assign hit_st = (idx == `LDOSCR_IDX_IRQ_STAT);
  assign hit_clr = (idx == `LDOSCR_IDX_IRQ_CLR);
  assign hit_en = (idx == `LDOSCR_IDX_IRQ_EN);
  assign mapped = aligned && (hit_a || hit_b || hit_on || hit_bs || hit_st || hit_clr || hit_en);

  // register fields
  always_comb
  begin
    nxt_a_slot = a_slot_ff;
    nxt_a_mode = a_mode_ff;
    nxt_a_vsel = a_vsel_ff;
    nxt_b_act = b_act_ff;
    nxt_b_src = b_src_ff;
    nxt_b_pick = b_pick_ff;
    nxt_b_hwm = b_hwm_ff;
    nxt_b_flt = b_flt_ff;
    nxt_b_swi = b_swi_ff;
    nxt_b_lp = b_lp_ff;
    nxt_b_on_vsel = b_on_vsel_ff;
    nxt_b_on_mode = b_on_mode_ff;
    nxt_b_slp_vsel = b_slp_vsel_ff;
    nxt_b_slp_mode = b_slp_mode_ff;
    if (wr && hit_a)
    begin
      nxt_a_slot = pwdata[`LDOSCR_SLOT_MSB:`LDOSCR_SLOT_LSB];
      nxt_a_mode = pwdata[`LDOSCR_MODE_BIT];
      nxt_a_vsel = pwdata[`LDOSCR_VSEL_MSB:`LDOSCR_VSEL_LSB];
    end
    if (wr && hit_b)
    begin
      nxt_b_act = pwdata[`LDOSCR_ACT_MSB:`LDOSCR_ACT_LSB];
      nxt_b_src = pwdata[`LDOSCR_SRC_MSB:`LDOSCR_SRC_LSB];
      nxt_b_pick = pwdata[`LDOSCR_PICK_BIT];
      nxt_b_hwm = pwdata[`LDOSCR_HWM_MSB:`LDOSCR_HWM_LSB];
      nxt_b_flt = pwdata[`LDOSCR_FLT_BIT];
      nxt_b_swi = pwdata[`LDOSCR_SWI_BIT];
      nxt_b_lp = pwdata[`LDOSCR_LP_BIT];
    end
    if (wr && hit_on)
    begin
      nxt_b_on_vsel = pwdata[`LDOSCR_VSEL_MSB:`LDOSCR_VSEL_LSB];
      nxt_b_on_mode = pwdata[`LDOSCR_MODE_BIT];
    end
    if (wr && hit_bs)
    begin
      nxt_b_slp_vsel = pwdata[`LDOSCR_VSEL_MSB:`LDOSCR_VSEL_LSB];
      nxt_b_slp_mode = pwdata[`LDOSCR_MODE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_slot_ff <= `LDOSCR_RST_SLOT;
      a_mode_ff <= `LDOSCR_RST_SLP_MODE;
      a_vsel_ff <= `LDOSCR_RST_VSEL;
      b_act_ff <= `LDOSCR_RST_ACT;
      b_src_ff <= `LDOSCR_RST_SRC;
      b_pick_ff <= `LDOSCR_RST_PICK;
      b_hwm_ff <= `LDOSCR_RST_HWM;
      b_flt_ff <= `LDOSCR_RST_FLT;
      b_swi_ff <= `LDOSCR_RST_SWI;
      b_lp_ff <= `LDOSCR_RST_LP;
      b_on_vsel_ff <= `LDOSCR_RST_VSEL;
      b_on_mode_ff <= `LDOSCR_RST_ON_MODE;
      b_slp_vsel_ff <= `LDOSCR_RST_VSEL;
      b_slp_mode_ff <= `LDOSCR_RST_SLP_MODE;
    end
    else
    begin
      a_slot_ff <= nxt_a_slot;
      a_mode_ff <= nxt_a_mode;
      a_vsel_ff <= nxt_a_vsel;
      b_act_ff <= nxt_b_act;
      b_src_ff <= nxt_b_src;
      b_pick_ff <= nxt_b_pick;
      b_hwm_ff <= nxt_b_hwm;
      b_flt_ff <= nxt_b_flt;
      b_swi_ff <= nxt_b_swi;
      b_lp_ff <= nxt_b_lp;
      b_on_vsel_ff <= nxt_b_on_vsel;
      b_on_mode_ff <= nxt_b_on_mode;
      b_slp_vsel_ff <= nxt_b_slp_vsel;
      b_slp_mode_ff <= nxt_b_slp_mode;
    end
  end

  assign fif.reg_a_sleep_slot = a_slot_ff;
  assign fif.reg_a_sleep_op_mode = a_mode_ff;
  assign fif.reg_a_sleep_voltage_code = a_vsel_ff;
  assign fif.reg_b_undervoltage_action = ldoscr_pkg::ldoscr_act_e'(b_act_ff);
  assign fif.reg_b_hw_control_source = ldoscr_pkg::ldoscr_src_e'(b_src_ff);
  assign fif.reg_b_hw_control_voltage_pick = b_pick_ff;
  assign fif.reg_b_hw_control_op_mode = ldoscr_pkg::ldoscr_hwmode_e'(b_hwm_ff);
  assign fif.reg_b_output_float = b_flt_ff;
  assign fif.reg_b_switch_select = b_swi_ff;
  assign fif.reg_b_low_power_variant = b_lp_ff;
  assign fif.reg_b_on_voltage_code = b_on_vsel_ff;
  assign fif.reg_b_on_op_mode = b_on_mode_ff;
  assign fif.reg_b_sleep_voltage_code = b_slp_vsel_ff;

  // read mux; unlisted bits stay zero
  always_comb
  begin
    rd = 32'h0000_0000;
    if (hit_a)
    begin
      rd[`LDOSCR_SLOT_MSB:`LDOSCR_SLOT_LSB] = a_slot_ff;
      rd[`LDOSCR_MODE_BIT] = a_mode_ff;
      rd[`LDOSCR_VSEL_MSB:`LDOSCR_VSEL_LSB] = a_vsel_ff;
    end
    else if (hit_b)
    begin
      rd[`LDOSCR_ACT_MSB:`LDOSCR_ACT_LSB] = b_act_ff;
      rd[`LDOSCR_SRC_MSB:`LDOSCR_SRC_LSB] = b_src_ff;
      rd[`LDOSCR_PICK_BIT] = b_pick_ff;
      rd[`LDOSCR_HWM_MSB:`LDOSCR_HWM_LSB] = b_hwm_ff;
      rd[`LDOSCR_FLT_BIT] = b_flt_ff;
      rd[`LDOSCR_SWI_BIT] = b_swi_ff;
      rd[`LDOSCR_LP_BIT] = b_lp_ff;
    end
    else if (hit_on)
    begin
      rd[`LDOSCR_MODE_BIT] = b_on_mode_ff;
      rd[`LDOSCR_VSEL_MSB:`LDOSCR_VSEL_LSB] = b_on_vsel_ff;
    end
    else if (hit_bs)
    begin
      rd[`LDOSCR_MODE_BIT] = b_slp_mode_ff;
      rd[`LDOSCR_VSEL_MSB:`LDOSCR_VSEL_LSB] = b_slp_vsel_ff;
    end
    else if (hit_st)
      rd[`LDOSCR_ST_W-1:0] = stat_ff;
    else if (hit_en)
      rd[`LDOSCR_ST_W-1:0] = en_ff;
  end

  // read data caught in the setup cycle so the access phase never waits
  always_comb
  begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (setup)
    begin
      nxt_prdata = (aligned && !pwrite) ? rd : 32'h0000_0000;
      nxt_pslverr = !mapped || (!pwrite && hit_clr) || (pwrite && hit_st);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff && psel && penable;

  // two flops for pins from outside; only the second stage feeds logic
  assign nxt_meta = {reg_b_undervoltage, hardware_control_2, hardware_control_1};
  assign nxt_sync = meta_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  ldoscr_sleep_slot u_sleep (
    .pclk(pclk),
    .presetn(presetn),
    .f(fif),
    .sleep_req(sleep_req),
    .wake_req(wake_req),
    .timeslot_strobe(timeslot_strobe),
    .timeslot_num(timeslot_num),
    .hw_enable_assigned(reg_a_hw_enable_assigned),
    .sleep_active(reg_a_sleep_active),
    .reg_off(reg_a_off),
    .evt_sleep(evt_sleep),
    .evt_off(evt_off)
  );

  assign reg_a_voltage_code = a_vsel_ff;
  assign reg_a_low_power = a_mode_ff;

  ldoscr_hw_ctrl u_hwc (
    .pclk(pclk),
    .presetn(presetn),
    .f(fif),
    .hw1(sync_ff[0]),
    .hw2(sync_ff[1]),
    .uv(sync_ff[2]),
    .uv_clr(clr_mask[`LDOSCR_ST_UV]),
    .seq_on(reg_b_seq_on),
    .enable(reg_b_enable),
    .voltage_code(reg_b_voltage_code),
    .low_power(reg_b_low_power),
    .discharge(reg_b_discharge),
    .switch_mode(reg_b_switch_mode),
    .lp_variant(reg_b_lp_variant),
    .hwc_active(reg_b_hwc_active),
    .sys_reset_req(system_reset_req),
    .uv_event(uv_event)
  );

  // sticky status; a set in the clearing cycle survives
  assign clr_mask = (wr && hit_clr) ? pwdata[`LDOSCR_ST_W-1:0] : `LDOSCR_RST_ST;
  assign evts = {evt_off, evt_sleep, uv_event};

  always_comb
  begin
    nxt_stat = (stat_ff & ~clr_mask) | evts;
    nxt_en = (wr && hit_en) ? pwdata[`LDOSCR_ST_W-1:0] : en_ff;
    nxt_irq = |(nxt_stat & nxt_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_ff <= `LDOSCR_RST_ST;
      en_ff <= `LDOSCR_RST_ST;
      irq_ff <= 1'b0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      en_ff <= nxt_en;
      irq_ff <= nxt_irq;
    end
  end

  assign irq = irq_ff;
endmodule // ldoscr_top
`default_nettype wire

// [sim/ldoscr_monitor.sv]
// port checker bound to the regulator control bank
`timescale 1ns/100ps
`default_nettype none
module ldoscr_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic reg_b_undervoltage,
  input wire logic timeslot_strobe,
  input wire logic wake_req,
  input wire logic reg_a_hw_enable_assigned,
  input wire logic reg_a_sleep_active,
  input wire logic reg_a_off,
  input wire logic reg_b_enable,
  input wire logic reg_b_discharge,
  input wire logic system_reset_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_sr1; system_reset_req |=> !system_reset_req; endproperty
  a_sr1: assert property (p_sr1) else $error("long reset req");
  // pin to request is two sync flops plus the event flop
  property p_sr2; system_reset_req |-> $past(reg_b_undervoltage, 3); endproperty
  a_sr2: assert property (p_sr2) else $error("reset req cause");
  property p_slp; $rose(reg_a_sleep_active) |-> $past(timeslot_strobe); endproperty
  a_slp: assert property (p_slp) else $error("sleep no strobe");
  property p_off; $rose(reg_a_off) |-> !$past(reg_a_hw_enable_assigned); endproperty
  a_off: assert property (p_off) else $error("off with hw enable");
  property p_ex; reg_a_off |-> !reg_a_sleep_active; endproperty
  a_ex: assert property (p_ex) else $error("off and sleep");
  property p_wk; wake_req |=> !reg_a_sleep_active && !reg_a_off; endproperty
  a_wk: assert property (p_wk) else $error("wake ignored");
  property p_dis; reg_b_enable |-> !reg_b_discharge; endproperty
  a_dis: assert property (p_dis) else $error("discharge while on");
endmodule // ldoscr_monitor
bind ldoscr_top ldoscr_monitor mon_u (.*);
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the regulator control bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [17:0] RA = 18'h101cc, RB = 18'h101d0, ST = 18'h10200;
  localparam logic [17:0] CL = 18'h10204, EN = 18'h10208;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic hardware_control_1 = 1'h0, hardware_control_2 = 1'h0, reg_b_undervoltage = 1'h0;
  logic sleep_req = 1'h0, wake_req = 1'h0, timeslot_strobe = 1'h0;
  logic reg_a_hw_enable_assigned = 1'h0, reg_b_seq_on = 1'h0, off;
  logic [2:0] timeslot_num = 3'h0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [4:0] reg_a_voltage_code, reg_b_voltage_code;
  logic pready, pslverr, reg_a_sleep_active, reg_a_off, reg_a_low_power, reg_b_enable;
  logic reg_b_low_power, reg_b_discharge, reg_b_switch_mode, reg_b_lp_variant;
  logic reg_b_hwc_active, system_reset_req, irq;
  logic [32:0] ex, expq [$];
  logic [15:0] hv [4] = '{16'h0f00, 16'h0dc0, 16'h1600, 16'h1800};
  logic [9:0] hs, he [4] = '{10'h3a2, 10'h1ab, 10'h054, 10'h25a};
  int error_cnt = 0, cmp_count = 0, seed = 32'ha15c, srq_n = 0, c, t, n;
  initial forever #2 pclk = ~pclk;
  ldoscr_top dut_u (.*);
  task chk(input string s, input logic [31:0] v, input logic [31:0] e);
    cmp_count++;
    if (v !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", s, e, v);
    end
  endtask
  task summarize;
    $display("compares %0d bad %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // idle edge first, so psel never gets two assignments in one step
  task apb(input logic w, input logic [17:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [17:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  always @(posedge pclk)
  begin
    if (system_reset_req === 1'h1)
      srq_n++;
    if (psel && penable && pready && !pwrite && expq.size() > 0)
    begin
      ex = expq.pop_front();
      chk("rdata", prdata, ex[31:0]);
      chk("rerr", pslverr, ex[32]);
    end
  end
  initial
  begin
    #20000;
    error_cnt++;
    summarize;
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd(RA, 33'h100);
    rd(RB, 33'h200);
    rd(18'h101d4, 33'h0);
    rd(18'h10000, 33'h100000000);
    for (c = 0; c < 6; c++)
    begin
      d = $random(seed);
      apb(1'h1, c[0] ? RB : RA, d);
      @(posedge pclk);
      #1;
      if (!c[0]) chk("vsel", {reg_a_low_power, reg_a_voltage_code}, {d[8], d[4:0]});
      if (c[0]) chk("lpv", reg_b_lp_variant, d[0]);
      rd(c[0] ? RB : RA, {1'h0, d & (c[0] ? 32'hdfc1 : 32'he11f)});
    end
    $display("regs done");
    apb(1'h1, EN, 32'h7);
    for (c = 0; c < 8; c++)
    begin
      t = c == 0 ? 5 : c == 6 ? 3 : c == 7 ? 1 : 6 - c;
      off = c > 0 && c < 6 && !c[0];
      reg_a_hw_enable_assigned <= c[0];
      apb(1'h1, RA, {16'h0, c[2:0], 13'h0});
      sleep_req <= 1'h1;
      @(posedge pclk);
      sleep_req <= 1'h0;
      timeslot_strobe <= 1'h1;
      timeslot_num <= 3'(t % 5 + 1);
      @(posedge pclk);
      timeslot_num <= 3'(t);
      #1;
      chk("early", reg_a_sleep_active | reg_a_off, 1'h0);
      @(posedge pclk);
      timeslot_strobe <= 1'h0;
      @(posedge pclk);
      #1;
      chk("slp", reg_a_sleep_active, !off);
      chk("off", reg_a_off, off);
      chk("irq", irq, 1'h1);
      rd(ST, off ? 33'h4 : 33'h2);
      apb(1'h1, CL, 32'h7);
      wake_req <= 1'h1;
      @(posedge pclk);
      wake_req <= 1'h0;
    end
    $display("sleep done");
    reg_b_seq_on <= 1'h1;
    for (c = 0; c < 4; c++)
    begin
      apb(1'h1, EN, {31'h0, c[0]});
      apb(1'h1, RB, {16'h0, c[1:0], 14'h0});
      n = srq_n;
      reg_b_undervoltage <= 1'h1;
      repeat (6) @(posedge pclk);
      reg_b_undervoltage <= 1'h0;
      #1;
      chk("srq", srq_n - n, c == 2);
      chk("en", reg_b_enable, c != 1);
      chk("irq", irq, c[0]);
      rd(ST, 33'h1);
      apb(1'h1, CL, 32'h7);
    end
    $display("uv done");
    reg_b_seq_on <= 1'h0;
    hardware_control_1 <= 1'h1;
    apb(1'h1, 18'h101d4, 32'h5);
    apb(1'h1, 18'h101d8, 32'h1a);
    for (c = 0; c < 4; c++)
    begin
      apb(1'h1, RB, {16'h0, hv[c]});
      repeat (2) @(posedge pclk);
      #1;
      hs = {reg_b_enable, reg_b_voltage_code, reg_b_low_power, reg_b_discharge,
        reg_b_hwc_active, reg_b_switch_mode};
      chk("hwc", hs, he[c]);
    end
    $display("hwc done");
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    chk("rst", {irq, reg_b_discharge, reg_a_low_power}, 3'h3);
    presetn <= 1'h1;
    rd(RB, 33'h200);
    $display("reset done");
    summarize;
  end
endmodule // tb_top
`default_nettype wire
